/* dsd_defines.vh */
// constants for the data space address decoder
`ifndef DSD_DEFINES_VH
`define DSD_DEFINES_VH
`define DSD_AW            24
`define DSD_DW            16
`define DSD_RAM_END       24'h001FFF
`define DSD_DFLASH_BASE   24'h002000
`define DSD_DFLASH_END    24'h002FFF
`define DSD_EXT_LO_END    24'h00EFFF
`define DSD_PERIPH_BASE   24'h00F000
`define DSD_PERIPH_END    24'h00FFFF
`define DSD_EXT_HI_END    24'hFFFEFF
`define DSD_DEBUG_BASE    24'hFFFF00
`define DSD_DBG_STATUS    8'hFD
`define DSD_DBG_DATA_LO   8'hFE
`define DSD_DBG_DATA_HI   8'hFF
`define DSD_DBG_SIGCTL    8'h8A
`define DSD_DBG_BPCNT     8'h8E
`define DSD_DBG_BLK_LO    8'h90
`define DSD_DBG_BLK_HI    8'hA0
`define DSD_DBG_LOCK      8'hFC
`define DSD_NPERIPH       29
`define DSD_PERIPH_BASES  {12'h800, 12'h400, 12'h360, 12'h350, 12'h340, 12'h330, \
  12'h320, 12'h310, 12'h300, 12'h2E0, 12'h2D0, 12'h2C0, 12'h2B0, 12'h2A0, \
  12'h290, 12'h280, 12'h270, 12'h240, 12'h200, 12'h1A0, 12'h190, 12'h180, \
  12'h160, 12'h140, 12'h100, 12'h0C0, 12'h080, 12'h040, 12'h020}
`define DSD_CFG_BASE      24'h01FFF7
`define DSD_CFG_WORDS     4'h9
`define DSD_CFG_LAST      4'h8
`define DSD_RAM_DEPTH     2048
`define DSD_RAM_IW        11
`define DSD_SECT_MSB      11
`define DSD_SECT_LSB      8
`define DSD_PF_SECT_LSB   9
`define DSD_PF_PAGE_LSB   13
`endif

/* dsd_data_ram.v */
// on-chip data ram, 2K entries of 32 bits
`default_nettype none
`include "dsd_defines.vh"
module dsd_data_ram #(
  parameter DEPTH = `DSD_RAM_DEPTH,
  parameter IW    = `DSD_RAM_IW
) (
  input  wire          clk,
  input  wire          en,
  input  wire          wrEn,
  input  wire          longOp,
  input  wire          halfSel,
  input  wire [IW-1:0] idx,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata_r
);
  reg [31:0] mem [0:DEPTH-1];

  // ----------------------------------------
  // one-cycle word or long-word access
  // ----------------------------------------
  always @(posedge clk) begin
    if (en) begin
      if (wrEn) begin
        if (longOp || !halfSel) begin
          mem[idx][15:0] <= wdata[15:0];
        end
        if (longOp) begin
          mem[idx][31:16] <= wdata[31:16];
        end else if (halfSel) begin
          mem[idx][31:16] <= wdata[15:0];
        end
      end
      rdata_r <= mem[idx];
    end
  end
endmodule // dsd_data_ram
`default_nettype wire

/* dsd_decoder.v */
// data space address decoder with flash configuration loader
`default_nettype none
`include "dsd_defines.vh"
module dsd_decoder #(
  parameter HAS_DATA_FLASH = 1,
  parameter NPERIPH        = `DSD_NPERIPH
) (
  input  wire                  clk,
  input  wire                  rst,
  input  wire [`DSD_AW-1:0]    busAddr,
  input  wire                  busRd,
  input  wire                  busWr,
  input  wire                  busLong,
  input  wire [31:0]           busWdata,
  input  wire                  dataExpansionModeBit,
  input  wire [`DSD_DW-1:0]    progFlashData,
  output reg                   ramSel_r,
  output reg  [31:0]           ramRdData_r,
  output reg                   dataFlashSel_r,
  output reg  [3:0]            dataFlashSector_r,
  output reg                   extMemSel_r,
  output reg                   periphSel_r,
  output reg  [NPERIPH-1:0]    periphSelVec_r,
  output reg                   debugSel_r,
  output reg                   debugDataLoSel_r,
  output reg                   debugDataHiSel_r,
  output reg                   debugStatusSel_r,
  output reg                   reservedHit_r,
  output reg                   accWr_r,
  output reg  [`DSD_AW-1:0]    accAddr_r,
  output reg  [31:0]           zeroRdData_r,
  output reg                   progFlashRd_r,
  output reg  [`DSD_AW-1:0]    progFlashAddr_r,
  output reg                   cfgWrEn_r,
  output reg  [3:0]            cfgIdx_r,
  output reg  [`DSD_DW-1:0]    cfgData_r,
  output reg                   cfgDone_r
);
  localparam [2:0] ST_READ  = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_DONE  = 3'h4;
  localparam [12*NPERIPH-1:0] BASES = `DSD_PERIPH_BASES;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function dbgDefined;
    input [7:0] off;
    begin
      dbgDefined = (off == `DSD_DBG_SIGCTL) || (off == `DSD_DBG_BPCNT) ||
                   (off >= `DSD_DBG_BLK_LO && off <= `DSD_DBG_BLK_HI) ||
                   (off >= `DSD_DBG_LOCK);
    end
  endfunction

  // ----------------------------------------
  // region decode
  // ----------------------------------------
  wire              acc      = busRd | busWr;
  wire              modeBit  = dataExpansionModeBit;
  wire [11:0]       pOff     = busAddr[11:0];
  wire              inDebug  = busAddr >= `DSD_DEBUG_BASE;
  wire              inPeriph = busAddr >= `DSD_PERIPH_BASE &&
                               busAddr <= `DSD_PERIPH_END;
  wire              inExtHi  = busAddr > `DSD_PERIPH_END &&
                               busAddr <= `DSD_EXT_HI_END;
  wire              inExtLo  = busAddr > `DSD_DFLASH_END &&
                               busAddr <= `DSD_EXT_LO_END;
  wire              inRam    = busAddr <= `DSD_RAM_END;
  wire              inDf     = busAddr >= `DSD_DFLASH_BASE &&
                               busAddr <= `DSD_DFLASH_END;
  wire              ramHit   = inRam && !modeBit;
  wire              dfHit    = inDf && !modeBit && (HAS_DATA_FLASH != 0);
  wire              lowExt   = modeBit && (inRam || inDf);
  wire [7:0]        dOff     = busAddr[7:0];

  // ----------------------------------------
  // peripheral selects, each ends at the next base, the last at the window end
  // ----------------------------------------
  wire [NPERIPH-1:0] geBase;
  wire [NPERIPH-1:0] pHit;
  genvar g;
  generate
    for (g = 0; g < NPERIPH; g = g + 1) begin : gPer
      assign geBase[g] = inPeriph && (pOff >= BASES[12*g +: 12]);
      if (g == NPERIPH - 1) begin : gTop
        assign pHit[g] = geBase[g];
      end else begin : gMid
        assign pHit[g] = geBase[g] && !geBase[g+1];
      end
    end
  endgenerate

  // ----------------------------------------
  // registered region selects
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ramSel_r          <= 1'b0;
      dataFlashSel_r    <= 1'b0;
      dataFlashSector_r <= 4'h0;
      extMemSel_r       <= 1'b0;
      periphSel_r       <= 1'b0;
      periphSelVec_r    <= {NPERIPH{1'b0}};
      debugSel_r        <= 1'b0;
      debugDataLoSel_r  <= 1'b0;
      debugDataHiSel_r  <= 1'b0;
      debugStatusSel_r  <= 1'b0;
      reservedHit_r     <= 1'b0;
      accWr_r           <= 1'b0;
      accAddr_r         <= {`DSD_AW{1'b0}};
      zeroRdData_r      <= 32'h00000000;
    end else begin
      ramSel_r          <= acc && ramHit;
      dataFlashSel_r    <= acc && dfHit;
      dataFlashSector_r <= busAddr[`DSD_SECT_MSB:`DSD_SECT_LSB];
      extMemSel_r       <= acc && (inExtHi || inExtLo || lowExt);
      periphSel_r       <= acc && inPeriph && (|pHit);
      periphSelVec_r    <= acc ? pHit : {NPERIPH{1'b0}};
      debugSel_r        <= acc && inDebug && dbgDefined(dOff);
      debugDataLoSel_r  <= acc && inDebug && dOff == `DSD_DBG_DATA_LO;
      debugDataHiSel_r  <= acc && inDebug && dOff == `DSD_DBG_DATA_HI;
      debugStatusSel_r  <= acc && inDebug && dOff == `DSD_DBG_STATUS;
      reservedHit_r     <= acc && ((inPeriph && !(|pHit)) ||
                                   (inDebug && !dbgDefined(dOff)));
      accWr_r           <= busWr;
      accAddr_r         <= busAddr;
      zeroRdData_r      <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // on-chip data ram
  // ----------------------------------------
  wire [31:0] ramQ;
  dsd_data_ram #(
    .DEPTH (`DSD_RAM_DEPTH),
    .IW    (`DSD_RAM_IW)
  ) uRam (
    .clk     (clk),
    .en      (acc && ramHit),
    .wrEn    (busWr),
    .longOp  (busLong),
    .halfSel (busAddr[0]),
    .idx     (busAddr[`DSD_RAM_IW:1]),
    .wdata   (busWdata),
    .rdata_r (ramQ)
  );

  always @(posedge clk) begin
    if (rst) begin
      ramRdData_r <= 32'h00000000;
    end else begin
      ramRdData_r <= ramQ;
    end
  end

  // ----------------------------------------
  // configuration word loader
  // ----------------------------------------
  reg [2:0] state_r;
  reg [3:0] idx_r;
  always @(posedge clk) begin
    if (rst) begin
      state_r         <= ST_READ;
      idx_r           <= 4'h0;
      progFlashRd_r   <= 1'b0;
      progFlashAddr_r <= {`DSD_AW{1'b0}};
      cfgWrEn_r       <= 1'b0;
      cfgIdx_r        <= 4'h0;
      cfgData_r       <= {`DSD_DW{1'b0}};
      cfgDone_r       <= 1'b0;
    end else begin
      progFlashRd_r <= 1'b0;
      cfgWrEn_r     <= 1'b0;
      case (state_r)
        ST_READ: begin
          progFlashRd_r   <= 1'b1;
          progFlashAddr_r <= `DSD_CFG_BASE + {20'h00000, idx_r};
          state_r         <= ST_WRITE;
        end
        ST_WRITE: begin
          cfgWrEn_r <= 1'b1;
          cfgIdx_r  <= idx_r;
          cfgData_r <= progFlashData;
          if (idx_r == `DSD_CFG_LAST) begin
            state_r   <= ST_DONE;
            cfgDone_r <= 1'b1;
          end else begin
            idx_r   <= idx_r + 4'h1;
            state_r <= ST_READ;
          end
        end
        ST_DONE: begin
          cfgDone_r <= 1'b1;
        end
        default: begin
          state_r <= ST_READ;
        end
      endcase
    end
  end
endmodule // dsd_decoder
`default_nettype wire

/* dsd_decoder_assertions.sv */
// checker for the data space address decoder
`default_nettype none
module dsd_decoder_chk #(
  parameter HAS_DATA_FLASH = 1,
  parameter NPERIPH        = 29
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               busRd,
  input wire logic               busWr,
  input wire logic               dataExpansionModeBit,
  input wire logic [23:0]        busAddr,
  input wire logic               ramSel_r,
  input wire logic               dataFlashSel_r,
  input wire logic [3:0]         dataFlashSector_r,
  input wire logic               extMemSel_r,
  input wire logic               periphSel_r,
  input wire logic [NPERIPH-1:0] periphSelVec_r,
  input wire logic               debugSel_r,
  input wire logic               debugDataLoSel_r,
  input wire logic               debugDataHiSel_r,
  input wire logic               debugStatusSel_r,
  input wire logic               reservedHit_r,
  input wire logic               accWr_r,
  input wire logic [23:0]        accAddr_r,
  input wire logic [31:0]        zeroRdData_r,
  input wire logic               progFlashRd_r,
  input wire logic               cfgWrEn_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       rq   = busRd | busWr;
  wire       m    = dataExpansionModeBit;
  wire [3:0] sect = busAddr[11:8];
  wire [7:0] dOff = busAddr[7:0];
  chk_ram_sel: assert property (
    rq && !m && busAddr <= 24'h001FFF |=> ramSel_r)
    else $error("ram select missing");
  chk_mode_low: assert property (
    rq && m && busAddr < 24'h003000 |=> extMemSel_r && !ramSel_r && !dataFlashSel_r)
    else $error("low range not external");
  chk_flash_sel: assert property (
    HAS_DATA_FLASH != 0 && rq && !m && busAddr[23:12] == 12'h002 |=>
    dataFlashSel_r && dataFlashSector_r == $past(sect))
    else $error("flash select wrong");
  chk_ext_lo: assert property (
    rq && busAddr >= 24'h003000 && busAddr <= 24'h00EFFF |=> extMemSel_r && !periphSel_r)
    else $error("low external missing");
  chk_ext_hi: assert property (
    rq && busAddr[23:16] != 8'h00 && busAddr < 24'hFFFF00 |=> extMemSel_r)
    else $error("high external missing");
  chk_dbg_win: assert property (
    rq && busAddr >= 24'hFFFF00 |=> !extMemSel_r && (debugSel_r || reservedHit_r))
    else $error("debug window wrong");
  chk_periph_one: assert property (
    rq && busAddr >= 24'h00F020 && busAddr <= 24'h00FFFF |=>
    periphSel_r && $onehot(periphSelVec_r))
    else $error("peripheral select wrong");
  chk_resv_zero: assert property (
    rq && busAddr[23:5] == 19'h00780 |=> reservedHit_r && zeroRdData_r == 32'h00000000)
    else $error("reserved hit wrong");
  chk_cfg_pair: assert property (
    progFlashRd_r |=> cfgWrEn_r && !progFlashRd_r)
    else $error("config write missing");
  chk_dbg_regs: assert property (
    rq && busAddr[23:8] == 16'hFFFF |=>
    debugDataLoSel_r == ($past(dOff) == 8'hFE) &&
    debugDataHiSel_r == ($past(dOff) == 8'hFF) &&
    debugStatusSel_r == ($past(dOff) == 8'hFD))
    else $error("debug register select wrong");
  chk_acc_copy: assert property (
    rq |=> accWr_r == $past(busWr) && accAddr_r == $past(busAddr))
    else $error("access copy wrong");
  chk_one_region: assert property (
    HAS_DATA_FLASH != 0 && rq |=>
    $onehot({ramSel_r, dataFlashSel_r, extMemSel_r, periphSel_r, debugSel_r, reservedHit_r}))
    else $error("region select not unique");
endmodule // dsd_decoder_chk
bind dsd_decoder dsd_decoder_chk #(
  .HAS_DATA_FLASH (HAS_DATA_FLASH),
  .NPERIPH        (NPERIPH)
) dsd_decoder_chk_i (.*);
`default_nettype wire

/* dsd_core_model.sv */
// core bus master and program flash model
`default_nettype none
module dsd_core_model (
  input wire logic         clk,
  input wire logic         progFlashRd_r,
  input wire logic [23:0]  progFlashAddr_r,
  output var logic [23:0]  busAddr,
  output var logic         busRd,
  output var logic         busWr,
  output var logic         busLong,
  output var logic [31:0]  busWdata,
  output var logic         dataExpansionModeBit,
  output var logic [15:0]  progFlashData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {busAddr, busRd, busWr, busLong, busWdata, dataExpansionModeBit} = '0;
  // one request per cycle; long only when requested and the address is outside the peripheral window
  task acc(input logic [23:0] a, input logic wr, lng, input logic [31:0] d, input logic md);
    @(negedge clk);
    busAddr = a;
    busRd = !wr;
    busWr = wr;
    busLong = lng && (a < 24'h00F000 || a > 24'h00FFFF);
    busWdata = d;
    dataExpansionModeBit = md;
  endtask
  task idle;
    @(negedge clk);
    busRd = 1'b0;
    busWr = 1'b0;
    busAddr = ~busAddr;
  endtask
  // flash word stands while the fetch strobe is high, inverse otherwise
  always_comb begin
    if (progFlashRd_r) begin
      progFlashData = {4'hA, progFlashAddr_r[11:0]};
    end else begin
      progFlashData = ~{4'hA, progFlashAddr_r[11:0]};
    end
  end
endmodule // dsd_core_model
`default_nettype wire

/* tb_dsd_decoder.sv */
// testbench for the data space address decoder
`default_nettype none
module tb_dsd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, busRd, busWr, busLong, dataExpansionModeBit, ramSel_r, dataFlashSel_r;
  logic extMemSel_r, periphSel_r, debugSel_r, reservedHit_r, progFlashRd_r, cfgWrEn_r, cfgDone_r;
  logic [23:0] busAddr, progFlashAddr_r, accAddr_r;
  logic [31:0] busWdata, ramRdData_r;
  logic [15:0] progFlashData, cfgData_r;
  logic [3:0]  cfgIdx_r, dataFlashSector_r;
  logic [28:0] periphSelVec_r;
  logic        debugDataLoSel_r, debugDataHiSel_r, debugStatusSel_r, accWr_r;
  int errors = 0, compares = 0, nCfg = 0;
  // mode, address, {ram, flash, ext, periph, debug, reserved}
  logic [30:0] rows [0:14] = '{
    {1'b0, 24'h000000, 6'h20}, {1'b0, 24'h001FFF, 6'h20}, {1'b0, 24'h002000, 6'h10},
    {1'b1, 24'h002FFF, 6'h08}, {1'b0, 24'h002FFF, 6'h10}, {1'b1, 24'h000000, 6'h08},
    {1'b0, 24'h003000, 6'h08}, {1'b1, 24'h00EFFF, 6'h08}, {1'b0, 24'h00F000, 6'h01},
    {1'b1, 24'h00F020, 6'h04}, {1'b0, 24'h00F800, 6'h04}, {1'b0, 24'h010000, 6'h08},
    {1'b1, 24'hFFFEFF, 6'h08}, {1'b1, 24'hFFFFFD, 6'h02}, {1'b0, 24'hFFFF00, 6'h01}};
  dsd_decoder dsd_decoder_i (.zeroRdData_r(), .*);
  dsd_core_model dsd_core_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task req(input logic [23:0] a, input logic wr, md);
    dsd_core_model_i.acc(a, wr, 1'b0, 32'h0, md);
    @(posedge clk);
    #1;
  endtask
  always @(negedge clk) if (!rst && cfgWrEn_r === 1'b1) begin
    chk("cfgIdx", cfgIdx_r, nCfg);
    chk("cfgData", cfgData_r, 16'hAFF7 + nCfg);
    nCfg++;
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(negedge clk);
    chk("resetOut", {ramSel_r, extMemSel_r, progFlashRd_r, cfgWrEn_r, cfgDone_r}, 0);
    rst = 1'b0;
    // ---------------------------------------
    // address map rows, back to back
    // ---------------------------------------
    for (int i = 0; i < 15; i++) begin
      dsd_core_model_i.acc(rows[i][29:6], 1'b0, 1'b0, 32'h0, rows[i][30]);
      @(posedge clk);
      #1;
      chk("selects", {ramSel_r, dataFlashSel_r, extMemSel_r, periphSel_r, debugSel_r,
        reservedHit_r}, rows[i][5:0]);
    end
    // ---------------------------------------
    // ram long write, upper-half word write, long read
    // ---------------------------------------
    dsd_core_model_i.acc(24'h000004, 1'b1, 1'b1, 32'h1234ABCD, 1'b0);
    dsd_core_model_i.acc(24'h000005, 1'b1, 1'b0, 32'h00005A5A, 1'b0);
    dsd_core_model_i.acc(24'h000004, 1'b0, 1'b1, 32'h0, 1'b0);
    dsd_core_model_i.idle;
    @(posedge clk);
    #1;
    chk("ramData", ramRdData_r, 32'h5A5AABCD);
    // ---------------------------------------
    // peripheral vector, debug registers, access copy
    // ---------------------------------------
    req(24'h00F020, 1'b0, 1'b1);
    chk("vecFirst", periphSelVec_r, 32'h00000001);
    req(24'h00F1A5, 1'b0, 1'b0);
    chk("vecMid", periphSelVec_r, 32'h00000200);
    req(24'h00F7FF, 1'b0, 1'b1);
    chk("vecFlashCtl", periphSelVec_r, 32'h08000000);
    req(24'h00F800, 1'b0, 1'b0);
    chk("vecLast", periphSelVec_r, 32'h10000000);
    req(24'hFFFFFE, 1'b0, 1'b1);
    chk("dbgLo", {debugDataLoSel_r, debugDataHiSel_r, debugStatusSel_r}, 32'h4);
    req(24'hFFFFFF, 1'b1, 1'b0);
    chk("dbgHi", {debugDataLoSel_r, debugDataHiSel_r, debugStatusSel_r}, 32'h2);
    chk("accCopy", {accWr_r, accAddr_r}, 32'h01FFFFFF);
    req(24'hFFFFFD, 1'b0, 1'b1);
    chk("dbgStatus", {debugDataLoSel_r, debugDataHiSel_r, debugStatusSel_r}, 32'h1);
    req(24'h002A00, 1'b0, 1'b0);
    chk("dfSector", dataFlashSector_r, 32'hA);
    for (int k = 0; k < 100 && cfgDone_r !== 1'b1; k++) @(negedge clk);
    if (cfgDone_r !== 1'b1) begin
      errors++;
    end else begin
      chk("cfgCount", nCfg, 9);
    end
    test_done;
  end
endmodule // tb_dsd_decoder
`default_nettype wire
